// ### verilog/dram_mode_pkg.sv
// Constants for the DRAM channel mode and refresh control block.
// Assumes a 20 MHz hub clock; register offsets are byte addresses.
// Summary of operation
// - refresh_rate_select 000 off, 001..100 give 15.6/7.8/3.9/1.95 us.
// - refresh_rate_select 111 gives fast refresh, one refresh per 64 clocks.
// - CKE outputs held low while reset is active.
// - After reset CKE stays low until special_command_mode written nonzero.
// - Suspend flushes pending commands, then puts ranks in self-refresh.
// - Resume resets the hub, clearing mode and holding CKE low.
// - C3 or S1 entry flushes commands and enters self-refresh on request.
// - Return to normal leaves self-refresh automatically without software.
// - Mode 001 turns host accesses into NOP, 010 into all-bank precharge.
// - Mode 011 gives mode register set, 100 extended; host address used.
// - Mode 110 turns host accesses into CBR refresh cycles.
// - Mode 111 gives normal read and write operation.
package dram_mode_pkg;
  localparam logic [11:0] MODE_CTRL_OFFSET = 12'h120;
  localparam int          INIT_DONE_BIT    = 29;
  localparam int          RATE_LSB         = 8;
  localparam int          MODE_LSB         = 4;
  localparam logic [31:0] MODE_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] MODE_CTRL_WMASK  = 32'h2000_0770;
  localparam int          CLK_MHZ          = 20;
  // Intervals in nanoseconds; counts round down so refresh never runs late
  localparam int          T_REF1_NS        = 15600;
  localparam int          T_REF2_NS        = 7800;
  localparam int          T_REF3_NS        = 3900;
  localparam int          T_REF4_NS        = 1950;
  localparam int          CNT_REF1 = T_REF1_NS * CLK_MHZ / 1000;
  localparam int          CNT_REF2 = T_REF2_NS * CLK_MHZ / 1000;
  localparam int          CNT_REF3 = T_REF3_NS * CLK_MHZ / 1000;
  localparam int          CNT_REF4 = T_REF4_NS * CLK_MHZ / 1000;
  localparam int          CNT_FAST = 64;
  localparam int          RCNT_W   = 10;
  localparam int          QCNT_W   = 4;
  localparam int          RANKS    = 4;

  localparam logic [2:0] RATE_OFF  = 3'h0;
  localparam logic [2:0] RATE_156  = 3'h1;
  localparam logic [2:0] RATE_78   = 3'h2;
  localparam logic [2:0] RATE_39   = 3'h3;
  localparam logic [2:0] RATE_195  = 3'h4;
  localparam logic [2:0] RATE_FAST = 3'h7;

  typedef enum logic [2:0] {
    SCM_POST_RESET = 3'h0,
    SCM_NOP        = 3'h1,
    SCM_PRECHARGE  = 3'h2,
    SCM_MRS        = 3'h3,
    SCM_EMRS       = 3'h4,
    SCM_RSVD       = 3'h5,
    SCM_CBR        = 3'h6,
    SCM_NORMAL     = 3'h7
  } scm_t;

  typedef enum logic [2:0] {
    CMD_NONE  = 3'h0,
    CMD_NOP   = 3'h1,
    CMD_PREA  = 3'h2,
    CMD_MRS   = 3'h3,
    CMD_EMRS  = 3'h4,
    CMD_REF   = 3'h5,
    CMD_RDWR  = 3'h6
  } dram_cmd_t;
endpackage

// ### verilog/refresh_timer.sv
// Refresh interval timer driven by the selected refresh rate.
// Assumes rate comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
module refresh_timer
  import dram_mode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] rate,
  output logic            tick
);
  logic [RCNT_W-1:0] cnt_reg;
  logic [RCNT_W-1:0] cnt_next;
  logic [2:0]        rate_reg;
  logic [2:0]        rate_next;
  logic              tick_next;
  logic [RCNT_W-1:0] reload;

  always_comb
  begin
    unique case (rate)
      RATE_156:  reload = RCNT_W'(CNT_REF1 - 1);
      RATE_78:   reload = RCNT_W'(CNT_REF2 - 1);
      RATE_39:   reload = RCNT_W'(CNT_REF3 - 1);
      RATE_195:  reload = RCNT_W'(CNT_REF4 - 1);
      RATE_FAST: reload = RCNT_W'(CNT_FAST - 1);
      default:   reload = '0;
    endcase
    rate_next = rate;
    tick_next = 1'b0;
    cnt_next  = cnt_reg;
    // Reserved codes behave as refresh disabled
    if (reload == '0)
      cnt_next = '0;
    else if (rate != rate_reg)
      cnt_next = reload;
    else if (cnt_reg == '0)
    begin
      cnt_next  = reload;
      tick_next = 1'b1;
    end
    else
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg  <= '0;
      rate_reg <= 3'h0;
      tick     <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      rate_reg <= rate_next;
      tick     <= tick_next;
    end
  end

  property p_fast_period;
    @(posedge clk) disable iff (!rstn)
      (tick && rate == RATE_FAST && $stable(rate)) ##1 (rate == RATE_FAST)
        [*8] |-> !tick;
  endproperty
  a_fast_period: assert property (p_fast_period)
    else $error("fast refresh tick too early");

  property p_off_no_tick;
    @(posedge clk) disable iff (!rstn)
      (rate == RATE_OFF) [*2] |=> !tick;
  endproperty
  a_off_no_tick: assert property (p_off_no_tick)
    else $error("refresh tick while refresh disabled");
endmodule
`default_nettype wire

// ### verilog/dram_mode_ctrl.sv
// Channel 0 DRAM mode control: mode register, CKE, self-refresh, command map.
// Assumes the hub register port, host request and power signals are on clk;
// power-state requests from other logic are synchronised here anyway.
`timescale 1ns/100ps
`default_nettype none
module dram_mode_ctrl
  import dram_mode_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [11:0]      reg_addr,
  input  wire logic [31:0]      reg_wdata,
  output logic      [31:0]      reg_rdata,
  input  wire logic             suspend_req,
  input  wire logic             lowpower_req,
  input  wire logic             host_req,
  input  wire logic             host_we,
  input  wire logic [13:0]      host_addr,
  input  wire logic             cmd_ack,
  output logic                  host_ack,
  output logic      [RANKS-1:0] cke,
  output logic                  dram_cmd_valid,
  output logic      [2:0]       dram_cmd,
  output logic                  dram_cmd_we,
  output logic      [13:0]      dram_addr,
  output logic                  self_refresh,
  output logic      [QCNT_W-1:0] refresh_pending,
  output logic                  init_done_flag
);
  typedef enum logic [1:0] {PW_RUN, PW_FLUSH, PW_SREF} pw_t;

  logic [2:0]        refresh_rate_select_reg, refresh_rate_select_next;
  scm_t              special_command_mode_reg, special_command_mode_next;
  logic              init_done_next;
  logic              cke_on_reg, cke_on_next;
  pw_t               pw_reg, pw_next;
  logic [1:0]        susp_sync, lp_sync;
  logic              sr_req;
  logic              tick;
  logic [QCNT_W-1:0] rq_next;
  logic              cmd_busy_next, host_ack_next, sref_next, cmd_we_next;
  logic [2:0]        cmd_next;
  logic [13:0]       daddr_next;
  logic [RANKS-1:0]  cke_next;
  logic [31:0]       rdata_next;
  logic              wr_hit, issue_ref, issue_host;

  refresh_timer refresh_timer_i (
    .clk  (clk),
    .rstn (rstn),
    .rate (refresh_rate_select_reg),
    .tick (tick)
  );

  // Suspend and C3/S1 requests come from another power domain controller
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      susp_sync <= 2'h0;
      lp_sync   <= 2'h0;
    end
    else
    begin
      susp_sync <= {susp_sync[0], suspend_req};
      lp_sync   <= {lp_sync[0], lowpower_req};
    end
  end
  assign sr_req = susp_sync[1] | lp_sync[1];

  assign wr_hit = reg_wr && (reg_addr == MODE_CTRL_OFFSET);

  // Register file and CKE enable
  always_comb
  begin
    refresh_rate_select_next  = refresh_rate_select_reg;
    special_command_mode_next = special_command_mode_reg;
    init_done_next            = init_done_flag;
    cke_on_next               = cke_on_reg;
    if (wr_hit)
    begin
      refresh_rate_select_next  = reg_wdata[RATE_LSB +: 3];
      special_command_mode_next = scm_t'(reg_wdata[MODE_LSB +: 3]);
      init_done_next            = reg_wdata[INIT_DONE_BIT];
      if (reg_wdata[MODE_LSB +: 3] != 3'h0)
        cke_on_next = 1'b1;
    end
    rdata_next = '0;
    if (reg_rd && reg_addr == MODE_CTRL_OFFSET)
    begin
      rdata_next[INIT_DONE_BIT]   = init_done_flag;
      rdata_next[RATE_LSB +: 3]   = refresh_rate_select_reg;
      rdata_next[MODE_LSB +: 3]   = special_command_mode_reg;
    end
  end

  // Power state: wait for in-flight command, then self-refresh
  always_comb
  begin
    pw_next = pw_reg;
    unique case (pw_reg)
      PW_RUN:   if (sr_req) pw_next = PW_FLUSH;
      PW_FLUSH: if (!dram_cmd_valid && refresh_pending == '0)
                  pw_next = PW_SREF;
      PW_SREF:  if (!sr_req) pw_next = PW_RUN;
    endcase
    sref_next = (pw_next == PW_SREF);
  end

  // Command issue: refresh has priority over host accesses
  always_comb
  begin
    issue_ref  = 1'b0;
    issue_host = 1'b0;
    rq_next    = refresh_pending;
    cmd_busy_next = dram_cmd_valid && !cmd_ack;
    cmd_next   = dram_cmd;
    cmd_we_next = dram_cmd_we;
    daddr_next = dram_addr;
    host_ack_next = 1'b0;
    if (!cmd_busy_next && pw_reg != PW_SREF && cke_on_reg)
    begin
      if (refresh_pending != '0)
        issue_ref = 1'b1;
      else if (host_req && pw_reg == PW_RUN && !host_ack)
        issue_host = 1'b1;
    end
    if (tick && refresh_pending != {QCNT_W{1'b1}})
      rq_next = rq_next + 1'b1;
    if (issue_ref)
    begin
      rq_next = rq_next - 1'b1;
      cmd_busy_next = 1'b1;
      cmd_next = CMD_REF;
      cmd_we_next = 1'b0;
    end
    if (issue_host)
    begin
      cmd_busy_next = 1'b1;
      host_ack_next = 1'b1;
      cmd_we_next = host_we;
      daddr_next  = host_addr;
      unique case (special_command_mode_reg)
        SCM_NOP:       cmd_next = CMD_NOP;
        SCM_PRECHARGE: cmd_next = CMD_PREA;
        SCM_MRS:       cmd_next = CMD_MRS;
        SCM_EMRS:      cmd_next = CMD_EMRS;
        SCM_CBR:       cmd_next = CMD_REF;
        SCM_NORMAL:    cmd_next = CMD_RDWR;
        default:
        begin
          // Reserved mode and post-reset state issue nothing
          cmd_next      = CMD_NONE;
          cmd_busy_next = 1'b0;
        end
      endcase
    end
    cke_next = {RANKS{cke_on_reg && !sref_next}};
  end

  // Resume from suspend arrives as a hub reset, so rstn covers it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refresh_rate_select_reg  <= MODE_CTRL_RESET[RATE_LSB +: 3];
      special_command_mode_reg <= SCM_POST_RESET;
      init_done_flag           <= MODE_CTRL_RESET[INIT_DONE_BIT];
      cke_on_reg               <= 1'b0;
      pw_reg                   <= PW_RUN;
      self_refresh             <= 1'b0;
      refresh_pending          <= '0;
      dram_cmd_valid           <= 1'b0;
      dram_cmd                 <= CMD_NONE;
      dram_cmd_we              <= 1'b0;
      dram_addr                <= '0;
      host_ack                 <= 1'b0;
      cke                      <= '0;
      reg_rdata                <= '0;
    end
    else
    begin
      refresh_rate_select_reg  <= refresh_rate_select_next;
      special_command_mode_reg <= special_command_mode_next;
      init_done_flag           <= init_done_next;
      cke_on_reg               <= cke_on_next;
      pw_reg                   <= pw_next;
      self_refresh             <= sref_next;
      refresh_pending          <= rq_next;
      dram_cmd_valid           <= cmd_busy_next;
      dram_cmd                 <= cmd_next;
      dram_cmd_we              <= cmd_we_next;
      dram_addr                <= daddr_next;
      host_ack                 <= host_ack_next;
      cke                      <= cke_next;
      reg_rdata                <= rdata_next;
    end
  end

  property p_cke_low_until_mode;
    @(posedge clk) disable iff (!rstn)
      (special_command_mode_reg == SCM_POST_RESET && !cke_on_reg)
        |-> cke == '0;
  endproperty
  a_cke_low_until_mode: assert property (p_cke_low_until_mode)
    else $error("cke raised before mode written");

  property p_cke_rises_on_write;
    @(posedge clk) disable iff (!rstn)
      (wr_hit && reg_wdata[MODE_LSB +: 3] != 3'h0 && !sr_req &&
       pw_reg == PW_RUN) |-> ##2 (cke == {RANKS{1'b1}});
  endproperty
  a_cke_rises_on_write: assert property (p_cke_rises_on_write)
    else $error("cke not raised after mode write");

  property p_sref_after_flush;
    @(posedge clk) disable iff (!rstn)
      $rose(self_refresh) |-> (cke == '0 || !cke_on_reg) ##0 !dram_cmd_valid;
  endproperty
  a_sref_after_flush: assert property (p_sref_after_flush)
    else $error("self refresh entered with command pending");

  property p_sref_cke;
    @(posedge clk) disable iff (!rstn)
      self_refresh |-> cke == '0;
  endproperty
  a_sref_cke: assert property (p_sref_cke)
    else $error("cke high during self refresh");

  property p_exit_sref;
    @(posedge clk) disable iff (!rstn)
      (self_refresh && !sr_req) |=> !self_refresh;
  endproperty
  a_exit_sref: assert property (p_exit_sref)
    else $error("self refresh not left on return");

  property p_cmd_map;
    @(posedge clk) disable iff (!rstn)
      (issue_host && special_command_mode_reg == SCM_MRS) |=>
        dram_cmd == CMD_MRS && dram_addr == $past(host_addr);
  endproperty
  a_cmd_map: assert property (p_cmd_map)
    else $error("mode register set not issued");

  property p_nop_map;
    @(posedge clk) disable iff (!rstn)
      (issue_host && special_command_mode_reg == SCM_NOP) |=>
        dram_cmd == CMD_NOP && host_ack;
  endproperty
  a_nop_map: assert property (p_nop_map)
    else $error("nop not issued");

  property p_init_flag;
    @(posedge clk) disable iff (!rstn)
      wr_hit |=> init_done_flag == $past(reg_wdata[INIT_DONE_BIT]);
  endproperty
  a_init_flag: assert property (p_init_flag)
    else $error("init flag not stored");
endmodule
`default_nettype wire

// ### verif/dram_rank_model.sv
// Far-side model of the DRAM ranks: accepts commands, counts illegal ones.
// Assumes a command is held as a level until cmd_ack is seen high.
`timescale 1ns/100ps
`default_nettype none
module dram_rank_model
  import dram_mode_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [3:0]       ack_delay,
  input  wire logic             dram_cmd_valid,
  input  wire logic [RANKS-1:0] cke,
  input  wire logic             self_refresh,
  output logic                  cmd_ack,
  output logic      [7:0]       bad_cmd
);
  logic [3:0] wait_cnt;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      bad_cmd  <= 8'h00;
    end
    else
    begin
      // Slow answers stretch the command so busy paths get exercised
      cmd_ack  <= dram_cmd_valid && !cmd_ack && (wait_cnt >= ack_delay);
      wait_cnt <= (dram_cmd_valid && !cmd_ack) ? wait_cnt + 4'h1 : 4'h0;
      // A rank with its clock gated or in self-refresh cannot take commands
      if (dram_cmd_valid && ((cke != {RANKS{1'b1}}) || self_refresh))
        bad_cmd <= bad_cmd + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### verif/dram_channel_mode_refresh_ctrl_tb.sv
// Self-checking bench for the channel mode and refresh controller.
// Assumes dram_rank_model answers the command port on the far side.
`timescale 1ns/100ps
`default_nettype none
module dram_channel_mode_refresh_ctrl_tb
  import dram_mode_pkg::*;
  ;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [11:0]       reg_addr = 12'h000;
  logic [31:0]       reg_wdata = 32'h0000_0000;
  logic              suspend_req = 1'b0;
  logic              lowpower_req = 1'b0;
  logic              host_req = 1'b0;
  logic              host_we = 1'b0;
  logic [13:0]       host_addr = 14'h0000;
  logic [3:0]        ack_delay = 4'h0;
  logic [31:0]       reg_rdata;
  logic              cmd_ack;
  logic              host_ack;
  logic [RANKS-1:0]  cke;
  logic              dram_cmd_valid;
  logic [2:0]        dram_cmd;
  logic              dram_cmd_we;
  logic [13:0]       dram_addr;
  logic              self_refresh;
  logic [QCNT_W-1:0] refresh_pending;
  logic              init_done_flag;
  logic [7:0]        bad_cmd;
  logic [31:0]       rd;
  int                cyc = 0;
  int                miscompares = 0;
  int                tests_run = 0;

  always #25 clk = ~clk;

  dram_mode_ctrl dram_mode_ctrl_i (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .suspend_req(suspend_req),
    .lowpower_req(lowpower_req), .host_req(host_req), .host_we(host_we),
    .host_addr(host_addr), .cmd_ack(cmd_ack), .host_ack(host_ack),
    .cke(cke), .dram_cmd_valid(dram_cmd_valid), .dram_cmd(dram_cmd),
    .dram_cmd_we(dram_cmd_we), .dram_addr(dram_addr),
    .self_refresh(self_refresh), .refresh_pending(refresh_pending),
    .init_done_flag(init_done_flag));

  dram_rank_model dram_rank_model_i (.clk(clk), .rstn(rstn),
    .ack_delay(ack_delay), .dram_cmd_valid(dram_cmd_valid), .cke(cke),
    .self_refresh(self_refresh), .cmd_ack(cmd_ack), .bad_cmd(bad_cmd));

  task automatic tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Sample time is the rising edge, before that edge's updates land
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask

  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    begin
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
    end
  endtask

  // Also serves as the resume reset after a suspend
  task automatic apply_reset;
    begin
      @(posedge clk);
      rstn <= 1'b0;
      wait_cycles(19);
      check(cke, 32'h0);
      rstn <= 1'b1;
    end
  endtask

  task automatic reg_scenario;
    begin
      reg_read(MODE_CTRL_OFFSET, rd);
      check(rd, 32'h0);
      check(cke, 32'h0);
      reg_write(MODE_CTRL_OFFSET, 32'h0000_0100);
      wait_cycles(4);
      check(cke, 32'h0);
      reg_write(MODE_CTRL_OFFSET, 32'hffff_ffff);
      wait_cycles(3);
      check(cke, 32'hf);
      reg_read(MODE_CTRL_OFFSET, rd);
      check(rd, 32'h2000_0770);
      check(init_done_flag, 32'h1);
      reg_write(12'h124, 32'h0);
      reg_read(12'h124, rd);
      check(rd, 32'h0);
      reg_read(MODE_CTRL_OFFSET, rd);
      check(rd, 32'h2000_0770);
    end
  endtask

  task automatic host_access(input logic [2:0] mode, input logic [2:0] exp);
    int i;
    begin
      reg_write(MODE_CTRL_OFFSET, {25'h0, mode, 4'h0});
      host_addr <= {11'h2b4, mode};
      host_we   <= mode[0];
      ack_delay <= mode[0] ? 4'h3 : 4'h0;
      host_req  <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
        @(posedge clk);
        if (host_ack)
          break;
      end
      host_req <= 1'b0;
      check(dram_cmd, exp);
      if (mode == 3'h3 || mode == 3'h4)
        check(dram_addr, {11'h2b4, mode});
      if (mode == 3'h7)
        check(dram_cmd_we, 32'h1);
      for (i = 0; i < 40 && dram_cmd_valid; i++)
        @(posedge clk);
    end
  endtask

  task automatic wait_ref(output logic hit);
    int i;
    begin
      hit = 1'b0;
      for (i = 0; i < 400 && !hit; i++)
      begin
        @(posedge clk);
        hit = dram_cmd_valid && (dram_cmd == CMD_REF) && !cmd_ack;
      end
    end
  endtask

  // Early refreshes may be queue drains, so the last gap is measured
  task automatic refresh_rate(input logic [2:0] rate, input int exp);
    int   k;
    int   stamp [4];
    logic hit;
    begin
      ack_delay <= 4'h0;
      reg_write(MODE_CTRL_OFFSET, {21'h0, rate, 8'h70});
      wait_cycles(20);
      for (k = 0; k < 4; k++)
      begin
        wait_ref(hit);
        stamp[k] = cyc;
        if (exp == 0)
          break;
      end
      if (exp == 0)
        check(hit, 32'h0);
      else
        check(stamp[3] - stamp[2], exp);
    end
  endtask

  task automatic power_cycle(input logic suspend);
    int i;
    begin
      reg_write(MODE_CTRL_OFFSET, 32'h0000_0770);
      wait_cycles(5);
      suspend_req  <= suspend;
      lowpower_req <= !suspend;
      for (i = 0; i < 60 && !self_refresh; i++)
        @(posedge clk);
      check(self_refresh, 32'h1);
      wait_cycles(1);
      check(cke, 32'h0);
      check(refresh_pending, 32'h0);
      suspend_req  <= 1'b0;
      lowpower_req <= 1'b0;
      if (suspend)
      begin
        apply_reset;
        reg_read(MODE_CTRL_OFFSET, rd);
        check(rd, 32'h0);
        check(cke, 32'h0);
        reg_write(MODE_CTRL_OFFSET, 32'h0000_0070);
      end
      for (i = 0; i < 60 && self_refresh; i++)
        @(posedge clk);
      wait_cycles(4);
      check(cke, 32'hf);
      host_access(3'h7, CMD_RDWR);
    end
  endtask

  initial
  begin
    apply_reset;
    reg_scenario;
    host_access(3'h1, CMD_NOP);
    host_access(3'h2, CMD_PREA);
    host_access(3'h3, CMD_MRS);
    host_access(3'h4, CMD_EMRS);
    host_access(3'h6, CMD_REF);
    host_access(3'h7, CMD_RDWR);
    refresh_rate(3'h1, 312);
    refresh_rate(3'h2, 156);
    refresh_rate(3'h3, 78);
    refresh_rate(3'h4, 39);
    refresh_rate(3'h7, 64);
    refresh_rate(3'h0, 0);
    refresh_rate(3'h5, 0);
    refresh_rate(3'h6, 0);
    power_cycle(1'b0);
    power_cycle(1'b1);
    check(bad_cmd, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
